// >>> rtl/irc_pkg.sv
// Functional notes
// - After power-on or full soft reset, stay 500 us in initialization before configuration.
// - During initialization the interrupt output toggles at the low-power oscillator rate.
// - On start, 1.5 ms analog stabilization, then first data interrupt one period later.
// - Status register clears when the host reads it, and on full or measurement path soft reset.
// - Channel data updates only when the valid-data interval of the period ends.
// - Only four clock combinations are valid; period is two chopper periods, whatever the ratio.
// - Writing zero to reset bit 7 forces full soft reset; bit 6 returns to one.
// - Reset bit 6 low resets only the measurement path registers.
// - Gain may change while running; first sample after the change is flagged invalid.
// - Input select, gain, bypass and current source writes are accepted while running.
// - Addresses 0x19 to 0x2c are read-only; writes there have no effect.
package irc_pkg;

    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int CLK_PERIOD_NS   = 50;
    localparam int INIT_TIME_US    = 500;
    localparam int STAB_TIME_US    = 1500;
    localparam int ADC_SLOW_US     = 1000;
    localparam int ADC_FAST_US     = 500;
    localparam int INVALID_TIME_US = 8;
    localparam int RDWIN_A_US      = 96;
    localparam int RDWIN_B_US      = 176;
    localparam int RDWIN_C_US      = 48;
    localparam int LPOSC_KHZ       = 262;

    // Least time in microseconds to clock cycles, rounded up.
    function automatic int cyc_up(input int us);
        cyc_up = (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    // Longest time in microseconds to clock cycles, rounded down.
    function automatic int cyc_dn(input int us);
        cyc_dn = (us * 1000) / CLK_PERIOD_NS;
    endfunction

    localparam int INIT_CYC_DEF     = cyc_up(INIT_TIME_US);
    localparam int STAB_CYC_DEF     = cyc_up(STAB_TIME_US);
    localparam int ADC_SLOW_CYC_DEF = cyc_up(ADC_SLOW_US);
    localparam int ADC_FAST_CYC_DEF = cyc_up(ADC_FAST_US);
    localparam logic [15:0] INVALID_CYC = 16'(cyc_up(INVALID_TIME_US));
    localparam logic [15:0] RDWIN_A_CYC = 16'(cyc_dn(RDWIN_A_US));
    localparam logic [15:0] RDWIN_B_CYC = 16'(cyc_dn(RDWIN_B_US));
    localparam logic [15:0] RDWIN_C_CYC = 16'(cyc_dn(RDWIN_C_US));
    localparam logic [7:0]  LPOSC_HALF_CYC = 8'((1000000 / CLK_PERIOD_NS) / (2 * LPOSC_KHZ));

    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam logic [6:0] ADDR_MODE     = 7'h00;
    localparam logic [6:0] ADDR_RESET    = 7'h09;
    localparam logic [6:0] ADDR_CLKCFG   = 7'h0a;
    localparam logic [6:0] ADDR_GAIN     = 7'h13;
    localparam logic [6:0] ADDR_BYPASS   = 7'h15;
    localparam logic [6:0] ADDR_VSEL     = 7'h17;
    localparam logic [6:0] ADDR_ISRC     = 7'h18;
    localparam logic [6:0] ADDR_RO_LO    = 7'h19;
    localparam logic [6:0] ADDR_RO_HI    = 7'h2c;
    localparam logic [6:0] ADDR_CUR_MSB  = 7'h19;
    localparam logic [6:0] ADDR_CUR_LSB  = 7'h1a;
    localparam logic [6:0] ADDR_VOLT_MSB = 7'h1b;
    localparam logic [6:0] ADDR_VOLT_LSB = 7'h1c;
    localparam logic [6:0] ADDR_STATUS   = 7'h1d;

    localparam logic [7:0] RESET_REG_RST = 8'hc0;
    localparam logic [7:0] CFG_REG_RST   = 8'h00;
    localparam logic [1:0] CLKCFG_RST    = 2'h0;

    localparam int RST_FULL_BIT = 7;
    localparam int RST_MEAS_BIT = 6;
    localparam int MODE_RUN_BIT = 0;
    localparam int STAT_READY   = 0;
    localparam int STAT_INVALID = 1;
    localparam int STAT_LATE    = 2;

    localparam int SPI_ADDR_BITS  = 8;
    localparam int SPI_FRAME_BITS = 16;

    // Valid clock combinations: modulator, chopper, first ratio.
    typedef enum logic [1:0] {
        CK_1M_2K_64,
        CK_2M_2K_64,
        CK_2M_2K_128,
        CK_2M_4K_64
    } irc_clk_t;

    typedef enum logic [1:0] {
        ST_INIT,
        ST_STOP,
        ST_STAB,
        ST_RUN
    } irc_state_t;

endpackage

// >>> rtl/irc_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
// Load and expiry handshake between the sequencer and its phase timer.
interface irc_tmr_if;
    logic        load;
    logic [15:0] load_val;
    logic        done;

    modport ctl (output load, output load_val, input done);
    modport tmr (input load, input load_val, output done);
endinterface
`default_nettype wire

// >>> rtl/irc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Phase timer: after a load of N, done is high in the N-th cycle.
module irc_timer (
    input  wire logic ref_clk_i,   // System clock.
    input  wire logic nrst_i,      // Asynchronous reset, active low.
    irc_tmr_if.tmr    tmr          // Load and expiry port.
);

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;

    // Count down to zero; a load restarts the count.
    always_comb begin
        cnt_nxt = cnt_r;
        if (tmr.load) begin
            cnt_nxt = tmr.load_val;
        end else if (cnt_r != 16'h0000) begin
            cnt_nxt = cnt_r - 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Expiry is seen while the last cycle of the phase runs.
    assign tmr.done = (cnt_r == 16'h0001) && !tmr.load;

endmodule
`default_nettype wire

// >>> rtl/irc_top.sv
`timescale 1ns/1ps
`default_nettype none
module irc_top
    import irc_pkg::*;
#(
    parameter int INIT_CYC     = INIT_CYC_DEF,
    parameter int STAB_CYC     = STAB_CYC_DEF,
    parameter int ADC_SLOW_CYC = ADC_SLOW_CYC_DEF,
    parameter int ADC_FAST_CYC = ADC_FAST_CYC_DEF
) (
    input  wire logic        ref_clk_i,      // System clock, 20 MHz.
    input  wire logic        nrst_i,         // Asynchronous reset, active low.
    input  wire logic        spi_sclk_i,     // Serial clock pin.
    input  wire logic        spi_cs_n_i,     // Serial chip select pin, active low.
    input  wire logic        spi_mosi_i,     // Serial data in pin.
    input  wire logic [15:0] cur_sample_i,   // Current channel filter output.
    input  wire logic [15:0] volt_sample_i,  // Voltage channel filter output.
    output logic             spi_miso_o,     // Serial data out.
    output logic             spi_miso_oe_o,  // Serial data out enable.
    output logic             int_o,          // Interrupt pin.
    output logic             adc_run_o,      // Conversion running.
    output logic             meas_rst_o,     // Measurement path reset pulse.
    output logic [7:0]       gain_o,         // Gain setting.
    output logic [7:0]       bypass_o,       // Amplifier bypass control.
    output logic [7:0]       vsel_o,         // Voltage input selection.
    output logic [7:0]       isrc_o,         // Current source control.
    output logic [1:0]       clk_sel_o       // Clock combination in use.
);

    // ***************************************************************
    // Pin synchronisers and serial frame state
    // ***************************************************************
    logic [2:0]  sclk_s_r, csn_s_r;
    logic [1:0]  mosi_s_r;
    logic [15:0] sh_r, sh_nxt;
    logic [7:0]  tx_r, tx_nxt;
    logic [4:0]  bit_r, bit_nxt;
    logic        rd_r, rd_nxt;
    logic        miso_r, miso_nxt;
    logic        oe_r, oe_nxt;
    logic        wr_stb, rd_stb;
    logic [6:0]  acc_addr;
    logic [7:0]  wr_data;
    logic        sclk_rise, sclk_fall, cs_act;

    // ***************************************************************
    // Sequencer state
    // ***************************************************************
    irc_state_t  st_r, st_nxt;
    irc_clk_t    clk_r, clk_nxt;
    logic [7:0]  mode_r, mode_nxt, rstreg_r, rstreg_nxt;
    logic [7:0]  gain_r, gain_nxt, byp_r, byp_nxt;
    logic [7:0]  vsel_r, vsel_nxt, isrc_r, isrc_nxt;
    logic [7:0]  stat_r, stat_nxt;
    logic [15:0] cur_r, cur_nxt, volt_r, volt_nxt;
    logic [15:0] per_r, per_nxt, win_r, win_nxt;
    logic [7:0]  lp_r, lp_nxt;
    logic        win_open_r, win_open_nxt, stat_rd_r, stat_rd_nxt;
    logic        pend_inv_r, pend_inv_nxt, int_r, int_nxt;
    logic        mrst_r, mrst_nxt, load_r, load_nxt, run_r, run_nxt;
    logic [15:0] period;

    irc_tmr_if tmr_if ();

    irc_timer u_timer (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .tmr       (tmr_if.tmr)
    );

    // Conversion period for a clock combination.
    function automatic logic [15:0] adc_cyc(input irc_clk_t c);
        adc_cyc = (c == CK_2M_4K_64) ? 16'(ADC_FAST_CYC) : 16'(ADC_SLOW_CYC);
    endfunction

    // Read window for a clock combination.
    function automatic logic [15:0] rdwin_cyc(input irc_clk_t c);
        case (c)
            CK_2M_2K_64: rdwin_cyc = RDWIN_B_CYC;
            CK_2M_4K_64: rdwin_cyc = RDWIN_C_CYC;
            default:     rdwin_cyc = RDWIN_A_CYC;
        endcase
    endfunction

    // Read data for an address; unmapped addresses read zero.
    function automatic logic [7:0] rd_mux(input logic [6:0] a);
        case (a)
            ADDR_MODE:     rd_mux = mode_r;
            ADDR_RESET:    rd_mux = rstreg_r;
            ADDR_CLKCFG:   rd_mux = {6'h00, clk_r};
            ADDR_GAIN:     rd_mux = gain_r;
            ADDR_BYPASS:   rd_mux = byp_r;
            ADDR_VSEL:     rd_mux = vsel_r;
            ADDR_ISRC:     rd_mux = isrc_r;
            ADDR_CUR_MSB:  rd_mux = cur_r[15:8];
            ADDR_CUR_LSB:  rd_mux = cur_r[7:0];
            ADDR_VOLT_MSB: rd_mux = volt_r[15:8];
            ADDR_VOLT_LSB: rd_mux = volt_r[7:0];
            ADDR_STATUS:   rd_mux = stat_r;
            default:       rd_mux = 8'h00;
        endcase
    endfunction

    assign sclk_rise = sclk_s_r[1] && !sclk_s_r[2];
    assign sclk_fall = !sclk_s_r[1] && sclk_s_r[2];
    assign cs_act    = !csn_s_r[1];
    assign period    = adc_cyc(clk_r);

    // Serial slave: mode 0, read flag then seven address bits, then data.
    always_comb begin
        sh_nxt   = sh_r;
        tx_nxt   = tx_r;
        bit_nxt  = bit_r;
        rd_nxt   = rd_r;
        miso_nxt = miso_r;
        oe_nxt   = cs_act;
        wr_stb   = 1'b0;
        rd_stb   = 1'b0;
        acc_addr = 7'h00;
        wr_data  = {sh_r[6:0], mosi_s_r[1]};
        if (!cs_act) begin
            bit_nxt  = 5'h00;
            rd_nxt   = 1'b0;
            miso_nxt = 1'b0;
        end else if (sclk_rise && bit_r < 5'(SPI_FRAME_BITS)) begin
            sh_nxt  = {sh_r[14:0], mosi_s_r[1]};
            bit_nxt = bit_r + 5'h01;
            if (bit_r == 5'(SPI_ADDR_BITS - 1)) begin
                acc_addr = {sh_r[5:0], mosi_s_r[1]};
                rd_nxt   = sh_r[6];
                rd_stb   = sh_r[6];
                tx_nxt   = rd_mux(acc_addr);
            end else if (bit_r == 5'(SPI_FRAME_BITS - 1)) begin
                acc_addr = sh_r[13:7];
                wr_stb   = !rd_r;
            end
        end else if (sclk_fall && rd_r) begin
            miso_nxt = tx_r[7];
            tx_nxt   = {tx_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_s_r <= 3'h0;
            csn_s_r  <= 3'h7;
            mosi_s_r <= 2'h0;
            sh_r     <= 16'h0000;
            tx_r     <= 8'h00;
            bit_r    <= 5'h00;
            rd_r     <= 1'b0;
            miso_r   <= 1'b0;
            oe_r     <= 1'b0;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], spi_sclk_i};
            csn_s_r  <= {csn_s_r[1:0], spi_cs_n_i};
            mosi_s_r <= {mosi_s_r[0], spi_mosi_i};
            sh_r     <= sh_nxt;
            tx_r     <= tx_nxt;
            bit_r    <= bit_nxt;
            rd_r     <= rd_nxt;
            miso_r   <= miso_nxt;
            oe_r     <= oe_nxt;
        end
    end

    // Phase timer is loaded on entry to initialization and stabilization.
    assign tmr_if.load     = load_r;
    assign tmr_if.load_val = (st_r == ST_STAB) ? 16'(STAB_CYC) : 16'(INIT_CYC);

    // Sequencer, register file and conversion timing.
    always_comb begin
        st_nxt       = st_r;
        clk_nxt      = clk_r;
        mode_nxt     = mode_r;
        rstreg_nxt   = rstreg_r;
        gain_nxt     = gain_r;
        byp_nxt      = byp_r;
        vsel_nxt     = vsel_r;
        isrc_nxt     = isrc_r;
        stat_nxt     = stat_r;
        cur_nxt      = cur_r;
        volt_nxt     = volt_r;
        per_nxt      = per_r;
        win_nxt      = win_r;
        lp_nxt       = lp_r;
        win_open_nxt = win_open_r;
        stat_rd_nxt  = stat_rd_r;
        pend_inv_nxt = pend_inv_r;
        int_nxt      = int_r;
        mrst_nxt     = 1'b0;
        load_nxt     = 1'b0;
        rstreg_nxt[RST_MEAS_BIT] = 1'b1;
        // Reading status clears it; events below set again, so set wins.
        if (rd_stb && acc_addr == ADDR_STATUS) begin
            stat_nxt    = 8'h00;
            stat_rd_nxt = 1'b1;
            int_nxt     = 1'b0;
        end
        case (st_r)
            ST_INIT: begin
                if (lp_r == LPOSC_HALF_CYC - 8'h01) begin
                    lp_nxt  = 8'h00;
                    int_nxt = !int_r;
                end else begin
                    lp_nxt = lp_r + 8'h01;
                end
                if (tmr_if.done) begin
                    st_nxt  = ST_STOP;
                    int_nxt = 1'b0;
                end
            end
            ST_STOP: begin
                if (mode_r[MODE_RUN_BIT]) begin
                    st_nxt   = ST_STAB;
                    load_nxt = 1'b1;
                end
            end
            ST_STAB: begin
                if (!mode_r[MODE_RUN_BIT]) begin
                    st_nxt = ST_STOP;
                end else if (tmr_if.done) begin
                    st_nxt  = ST_RUN;
                    per_nxt = 16'h0000;
                end
            end
            ST_RUN: begin
                if (!mode_r[MODE_RUN_BIT]) begin
                    st_nxt       = ST_STOP;
                    int_nxt      = 1'b0;
                    win_open_nxt = 1'b0;
                end else begin
                    per_nxt = (per_r == period - 16'h0001) ? 16'h0000 : per_r + 16'h0001;
                    // Data changes only when the valid-data interval has ended.
                    if (per_r == period - INVALID_CYC) begin
                        cur_nxt      = cur_sample_i;
                        volt_nxt     = volt_sample_i;
                        pend_inv_nxt = 1'b0;
                        if (pend_inv_r) begin
                            stat_nxt[STAT_INVALID] = 1'b1;
                        end
                    end
                    // Open the read window with the data interrupt.
                    if (per_r == period - 16'h0001) begin
                        int_nxt              = 1'b1;
                        stat_nxt[STAT_READY] = 1'b1;
                        win_open_nxt         = 1'b1;
                        win_nxt              = 16'h0000;
                        stat_rd_nxt          = 1'b0;
                    end else if (win_open_r) begin
                        win_nxt = win_r + 16'h0001;
                        if (win_r == rdwin_cyc(clk_r) - 16'h0001) begin
                            win_open_nxt = 1'b0;
                            int_nxt      = 1'b0;
                            if (!stat_rd_r) begin
                                stat_nxt[STAT_LATE] = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                st_nxt = ST_INIT;
            end
        endcase
        // Writes are ignored while initializing.
        if (wr_stb && st_r != ST_INIT) begin
            case (acc_addr)
                ADDR_MODE:   mode_nxt = wr_data;
                ADDR_CLKCFG: begin
                    if (st_r == ST_STOP) begin
                        clk_nxt = irc_clk_t'(wr_data[1:0]);
                    end
                end
                ADDR_GAIN: begin
                    gain_nxt = wr_data;
                    if (st_r == ST_RUN && wr_data != gain_r) begin
                        pend_inv_nxt = 1'b1;
                    end
                end
                ADDR_BYPASS: byp_nxt  = wr_data;
                ADDR_VSEL:   vsel_nxt = wr_data;
                ADDR_ISRC:   isrc_nxt = wr_data;
                ADDR_RESET: begin
                    if (!wr_data[RST_FULL_BIT]) begin
                        st_nxt       = ST_INIT;
                        load_nxt     = 1'b1;
                        lp_nxt       = 8'h00;
                        int_nxt      = 1'b0;
                        mode_nxt     = CFG_REG_RST;
                        rstreg_nxt   = RESET_REG_RST;
                        clk_nxt      = irc_clk_t'(CLKCFG_RST);
                        gain_nxt     = CFG_REG_RST;
                        byp_nxt      = CFG_REG_RST;
                        vsel_nxt     = CFG_REG_RST;
                        isrc_nxt     = CFG_REG_RST;
                        stat_nxt     = 8'h00;
                        cur_nxt      = 16'h0000;
                        volt_nxt     = 16'h0000;
                        win_open_nxt = 1'b0;
                        pend_inv_nxt = 1'b0;
                    end else if (!wr_data[RST_MEAS_BIT]) begin
                        rstreg_nxt[RST_MEAS_BIT] = 1'b0;
                        mrst_nxt     = 1'b1;
                        stat_nxt     = 8'h00;
                        cur_nxt      = 16'h0000;
                        volt_nxt     = 16'h0000;
                        per_nxt      = 16'h0000;
                        win_open_nxt = 1'b0;
                        pend_inv_nxt = 1'b0;
                    end
                end
                default: begin
                    // Results, status and unmapped addresses ignore writes.
                    mode_nxt = mode_nxt;
                end
            endcase
        end
        // Registered run flag, so the pin comes straight from a flop.
        run_nxt = (st_nxt == ST_RUN);
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r       <= ST_INIT;
            clk_r      <= irc_clk_t'(CLKCFG_RST);
            mode_r     <= CFG_REG_RST;
            rstreg_r   <= RESET_REG_RST;
            gain_r     <= CFG_REG_RST;
            byp_r      <= CFG_REG_RST;
            vsel_r     <= CFG_REG_RST;
            isrc_r     <= CFG_REG_RST;
            stat_r     <= 8'h00;
            cur_r      <= 16'h0000;
            volt_r     <= 16'h0000;
            per_r      <= 16'h0000;
            win_r      <= 16'h0000;
            lp_r       <= 8'h00;
            win_open_r <= 1'b0;
            stat_rd_r  <= 1'b0;
            pend_inv_r <= 1'b0;
            int_r      <= 1'b0;
            mrst_r     <= 1'b0;
            load_r     <= 1'b1;
            run_r      <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            clk_r      <= clk_nxt;
            mode_r     <= mode_nxt;
            rstreg_r   <= rstreg_nxt;
            gain_r     <= gain_nxt;
            byp_r      <= byp_nxt;
            vsel_r     <= vsel_nxt;
            isrc_r     <= isrc_nxt;
            stat_r     <= stat_nxt;
            cur_r      <= cur_nxt;
            volt_r     <= volt_nxt;
            per_r      <= per_nxt;
            win_r      <= win_nxt;
            lp_r       <= lp_nxt;
            win_open_r <= win_open_nxt;
            stat_rd_r  <= stat_rd_nxt;
            pend_inv_r <= pend_inv_nxt;
            int_r      <= int_nxt;
            mrst_r     <= mrst_nxt;
            load_r     <= load_nxt;
            run_r      <= run_nxt;
        end
    end

    // Outputs come straight from flip-flops.
    assign spi_miso_o    = miso_r;
    assign spi_miso_oe_o = oe_r;
    assign int_o         = int_r;
    assign adc_run_o     = run_r;
    assign meas_rst_o    = mrst_r;
    assign gain_o        = gain_r;
    assign bypass_o      = byp_r;
    assign vsel_o        = vsel_r;
    assign isrc_o        = isrc_r;
    assign clk_sel_o     = clk_r;

endmodule
`default_nettype wire

// >>> bench/irc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the sequencer pins for start-up, reset and interrupt timing.
module irc_top_asserts #(parameter int INIT_CYC = 200) (
    input  wire logic       ref_clk_i,   // System clock.
    input  wire logic       nrst_i,      // Reset, active low.
    input  wire logic       int_o,       // Interrupt pin.
    input  wire logic       adc_run_o,   // Conversion running.
    input  wire logic       meas_rst_o,  // Measurement path reset.
    input  wire logic [7:0] gain_o,      // Gain setting.
    input  wire logic [7:0] vsel_o,      // Input selection.
    input  wire logic [1:0] clk_sel_o    // Clock combination.
);
    int unsigned age_r;
    // Counts cycles since reset release and stops at the init length.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            age_r <= 0;
        end else if (age_r < INIT_CYC) begin
            age_r <= age_r + 1;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // Start-up idle, held settings and pin behaviour.
    property p_init_tgl; $rose(nrst_i) |-> ##[1:80] $changed(int_o); endproperty
    a_init_tgl: assert property (p_init_tgl) else $error("interrupt pin idle in init");
    property p_init_idle; age_r < INIT_CYC |-> !adc_run_o; endproperty
    a_init_idle: assert property (p_init_idle) else $error("conversion in init");
    property p_init_cfg; age_r < INIT_CYC |-> gain_o == 8'h00 && vsel_o == 8'h00; endproperty
    a_init_cfg: assert property (p_init_cfg) else $error("settings moved in init");
    property p_mrst_pulse; meas_rst_o |=> !meas_rst_o; endproperty
    a_mrst_pulse: assert property (p_mrst_pulse) else $error("path reset too long");
    property p_mrst_keep; meas_rst_o |=> $stable(gain_o) && $stable(vsel_o); endproperty
    a_mrst_keep: assert property (p_mrst_keep) else $error("path reset hit settings");
    property p_clk_hold; adc_run_o |=> $stable(clk_sel_o); endproperty
    a_clk_hold: assert property (p_clk_hold) else $error("clock setting moved in run");
    property p_first_int; $rose(adc_run_o) |-> !int_o [*8]; endproperty
    a_first_int: assert property (p_first_int) else $error("early interrupt");
    property p_int_hold; $rose(int_o) && adc_run_o |-> int_o [*8]; endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt dropped early");
endmodule
bind irc_top irc_top_asserts #(.INIT_CYC(INIT_CYC)) i_irc_top_asserts (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .int_o(int_o), .adc_run_o(adc_run_o), .meas_rst_o(meas_rst_o),
    .gain_o(gain_o), .vsel_o(vsel_o), .clk_sel_o(clk_sel_o));
`default_nettype wire

// >>> bench/irc_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial port: mode 0, read flag first, each level held 4 clocks.
module irc_host (
    input  wire logic ref_clk_i,   // System clock.
    input  wire logic spi_miso_i,  // Data from device.
    output var logic  sclk_o,      // Serial clock, idle low.
    output var logic  cs_n_o,      // Chip select, active low.
    output var logic  mosi_o       // Data to device.
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // One whole frame; the data line is inverted once released so stale bits never look valid.
    task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
        cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_o = f[i];
            repeat (4) @(posedge ref_clk_i);
            #1 rd = {rd[6:0], spi_miso_i};
            sclk_o = 1'b1;
            repeat (4) @(posedge ref_clk_i);
            #1 sclk_o = 1'b0;
        end
        repeat (4) @(posedge ref_clk_i);
        #1 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import irc_pkg::*;
    logic       ref_clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       sclk, cs_n, mosi, miso, run, irq, mrst, seen_mrst = 1'b0, oe, seen_oe = 1'b0;
    logic [7:0] gain, rd, vsel, byp, isrc;
    logic [1:0] csel;
    int         fails = 0;
    int         checks_done = 0;
    int         cyc = 0;
    irc_top #(.INIT_CYC(200), .STAB_CYC(300), .ADC_SLOW_CYC(4000), .ADC_FAST_CYC(2000)) i_irc_top (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .cur_sample_i(16'habcd), .volt_sample_i(16'h1234), .spi_miso_o(miso), .spi_miso_oe_o(oe),
        .int_o(irq), .adc_run_o(run), .meas_rst_o(mrst), .gain_o(gain), .bypass_o(byp), .vsel_o(vsel),
        .isrc_o(isrc), .clk_sel_o(csel));
    irc_host i_irc_host (.ref_clk_i(ref_clk_i), .spi_miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
    // Clock, path reset watcher and hang guard.
    always #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc++;
        if (mrst === 1'b1) seen_mrst = 1'b1;
        if (oe === 1'b1) seen_oe = 1'b1;
        if (cyc == 40000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_irc_host.xfer({1'b0, a, d}, rd);
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        i_irc_host.xfer({1'b1, a, 8'h00}, rd);
        chk(rd, exp);
    endtask
    // Waits a bounded time for a data interrupt.
    task automatic wait_int();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 5000) begin
            @(posedge ref_clk_i);
            #1 n++;
        end
        chk({7'h00, irq}, 8'h01);
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Start-up, conversion, gain change, path reset and full soft reset in turn.
    initial begin
        repeat (4) @(posedge ref_clk_i);
        #1 nrst_i = 1'b1;
        wr(ADDR_GAIN, 8'h05);
        repeat (200) @(posedge ref_clk_i);
        #1 chk(gain, 8'h00);
        rdchk(ADDR_RESET, RESET_REG_RST);
        chk({6'h00, seen_oe, oe}, 8'h02);
        wr(ADDR_CLKCFG, 8'h01);
        chk({6'h00, csel}, 8'h01);
        $display("test init ended");
        wr(ADDR_MODE, 8'h01);
        wait_int();
        rdchk(ADDR_STATUS, 8'h01);
        rdchk(ADDR_STATUS, 8'h00);
        wr(ADDR_CUR_MSB, 8'h55);
        rdchk(ADDR_CUR_MSB, 8'hab);
        $display("test start ended");
        wr(ADDR_GAIN, 8'h19);
        chk(gain, 8'h19);
        wr(ADDR_VSEL, 8'h02);
        wr(ADDR_BYPASS, 8'h01);
        wr(ADDR_ISRC, 8'h03);
        chk(vsel, 8'h02);
        chk(byp, 8'h01);
        chk(isrc, 8'h03);
        wait_int();
        rdchk(ADDR_STATUS, 8'h03);
        wait_int();
        rdchk(ADDR_STATUS, 8'h01);
        $display("test gain ended");
        wr(ADDR_MODE, 8'h00);
        chk({7'h00, run}, 8'h00);
        wr(ADDR_RESET, 8'h80);
        chk({7'h00, seen_mrst}, 8'h01);
        chk(gain, 8'h19);
        rdchk(ADDR_RESET, 8'hc0);
        wr(ADDR_CLKCFG, 8'h03);
        chk({6'h00, csel}, 8'h03);
        wr(ADDR_MODE, 8'h01);
        wait_int();
        rdchk(ADDR_STATUS, 8'h01);
        wr(ADDR_MODE, 8'h00);
        $display("test path reset ended");
        wr(ADDR_RESET, 8'h40);
        wr(ADDR_GAIN, 8'h07);
        chk(gain, 8'h00);
        chk(vsel, 8'h00);
        $display("test soft reset ended");
        close_out();
    end
endmodule
`default_nettype wire
